// ### bmap_pkg.sv
// constants and types for boot mode capture and program map decode
// Operation
// - reset loads secure bit and map bit
// - secured plus strap high forces both zero
// - secured internal boot: narrow, no external, debug off
// - both bits set: external boot, width strap
// - secure bit changes only at reset
// - software secure bit write changes only the write-ignored flag
// - map bit writable only if secure bit set
// - chip selects start as program/data strobes
// - wide strap enables address bits 19:16 only on unsecured external boot
// - internal boot vectors at 04 0000/0002
// - narrow external boot vectors at 00 0000/0002
// - wide external boot overlays boot flash
// - narrow bus: above 00 FFFF reachable only with mid or top address pins
// - 10 0000 and up need extra pins
// - two flash blocks, independent busy and erase
package bmap_pkg;
	// program word address width, 00 0000 to 1f ffff
	localparam int PA_W = 21;
	typedef logic [PA_W-1:0] bmap_addr_t;

	// region select, one-hot
	localparam int RG_W = 5;
	typedef logic [RG_W-1:0] bmap_region_t;
	localparam bmap_region_t RG_FLASH = 5'h01;
	localparam bmap_region_t RG_BOOT  = 5'h02;
	localparam bmap_region_t RG_PRAM  = 5'h04;
	localparam bmap_region_t RG_RSVD  = 5'h08;
	localparam bmap_region_t RG_EXT   = 5'h10;
	localparam bmap_region_t RG_NONE  = 5'h00;

	// map boundaries
	localparam bmap_addr_t EXT_LO_END = 21'h00ffff;
	localparam bmap_addr_t FLASH_END  = 21'h03ffff;
	localparam bmap_addr_t BOOT_END   = 21'h043fff;
	localparam bmap_addr_t PRAM_BASE  = 21'h04f800;
	localparam bmap_addr_t PRAM_END   = 21'h04ffff;
	localparam bmap_addr_t NARROW_LIM = 21'h010000;
	localparam bmap_addr_t TOP_LIM    = 21'h100000;

	// vector locations
	localparam bmap_addr_t VEC_INT_BOOT = 21'h040000;
	localparam bmap_addr_t VEC_INT_WDOG = 21'h040002;
	localparam bmap_addr_t VEC_EXT_BOOT = 21'h000000;
	localparam bmap_addr_t VEC_EXT_WDOG = 21'h000002;

	// bit that splits the two flash blocks
	localparam int FLASH_BLK_BIT = 17;
	localparam int NBLK          = 2;

	// synchroniser depth before straps are trusted
	localparam logic [1:0] SYNC_WAIT = 2'h2;

	// reset values
	localparam logic RST_BIT  = 1'b0;
	localparam logic RST_ROLE = 1'b1;

	// capture sequence states
	typedef enum logic [2:0] {
		ST_SYNC = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN  = 3'b100
	} bmap_state_e;
endpackage : bmap_pkg

// ### bmap_top.sv
// boot mode capture and program space region decode
`timescale 1ns/100ps
module bmap_top (
	// clock and reset
	input  wire  logic                  ref_clk_in,
	input  wire  logic                  resetn_in,
	// straps and flash state
	input  wire  logic                  external_boot_strap_in,
	input  wire  logic                  wide_address_strap_in,
	input  wire  logic                  flash_secured_in,
	// software writes to the operating mode register
	input  wire  logic                  map_select_wr_in,
	input  wire  logic                  map_select_wdata_in,
	input  wire  logic                  secure_boot_wr_in,
	// software pin reconfiguration
	input  wire  logic                  mid_addr_pins_in,
	input  wire  logic                  top_addr_pins_in,
	// fetch request
	input  wire  logic                  fetch_valid_in,
	input  wire  bmap_pkg::bmap_addr_t  fetch_addr_in,
	// flash block control
	input  wire  logic [1:0]            flash_busy_in,
	input  wire  logic [1:0]            erase_req_in,
	// mode state
	output logic                        mode_ready_out,
	output logic                        map_select_bit_out,
	output logic                        secure_boot_bit_out,
	output logic                        wide_bus_out,
	output logic                        debug_enable_out,
	output logic                        ext_pspace_allow_out,
	output logic [3:0]                  addr_hi_pins_out,
	output logic                        chip_select_zero_out,
	output logic                        chip_select_one_out,
	output logic                        sb_write_ignored_out,
	// vectors
	output bmap_pkg::bmap_addr_t        boot_vector_out,
	output bmap_pkg::bmap_addr_t        wdog_vector_out,
	// fetch answer
	output bmap_pkg::bmap_region_t      region_out,
	output logic                        flash_block_out,
	output logic                        fetch_stall_out,
	// flash erase launch
	output logic [1:0]                  mass_erase_out
);
	import bmap_pkg::*;

	// reachability of external space for a given address
	function automatic logic ext_reach(
		input bmap_addr_t a,
		input logic       sec,
		input logic       wide,
		input logic       mid,
		input logic       top
	);
		logic r;
		r = 1'b0;
		if (!sec) begin
			r = 1'b0;
		end else if (a >= TOP_LIM) begin
			r = top;
		end else if (a >= NARROW_LIM) begin
			r = wide | mid | top;
		end else begin
			r = 1'b1;
		end
		return r;
	endfunction : ext_reach

	// region of one fetch address
	function automatic bmap_region_t map_region(
		input bmap_addr_t a,
		input logic       ext_map,
		input logic       wide,
		input logic       reach
	);
		bmap_region_t r;
		r = RG_RSVD;
		if (ext_map && !wide && a <= EXT_LO_END) begin
			r = RG_EXT;
		end else if (a <= FLASH_END) begin
			r = RG_FLASH;
		end else if (a <= BOOT_END) begin
			// wide external boot shadows boot flash
			r = (ext_map && wide) ? RG_EXT : RG_BOOT;
		end else if (a < PRAM_BASE) begin
			r = RG_RSVD;
		end else if (a <= PRAM_END) begin
			r = RG_PRAM;
		end else begin
			// unreachable external falls back to reserved
			r = reach ? RG_EXT : RG_RSVD;
		end
		return r;
	endfunction : map_region

	// strap synchronisers, first stage read only by second
	logic        xb_s1_q;   // external boot, stage one
	logic        xb_s2_q;   // external boot, stage two
	logic        wa_s1_q;   // wide strap, stage one
	logic        wa_s2_q;   // wide strap, stage two

	// capture sequence
	bmap_state_e st_q;      // sequence state
	bmap_state_e st_d;
	logic [1:0]  cnt_q;     // sync wait count
	logic [1:0]  cnt_d;

	// mode bits
	logic        sec_q;     // secure boot bit
	logic        sec_d;
	logic        map_q;     // map select bit
	logic        map_d;
	logic        wide_q;    // wide bus chosen at boot
	logic        wide_d;
	logic        ign_q;     // secure bit write dropped
	logic        ign_d;

	// fetch answer
	bmap_region_t rg_q;
	bmap_region_t rg_d;
	logic        blk_q;
	logic        blk_d;
	logic        stall_q;
	logic        stall_d;
	logic [1:0]  ers_q;
	logic [1:0]  ers_d;
	bmap_addr_t  bv_q;
	bmap_addr_t  bv_d;
	bmap_addr_t  wv_q;
	bmap_addr_t  wv_d;

	// pins are asynchronous: two flops before any use
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			xb_s1_q <= RST_BIT;
			xb_s2_q <= RST_BIT;
			wa_s1_q <= RST_BIT;
			wa_s2_q <= RST_BIT;
		end else begin
			xb_s1_q <= external_boot_strap_in;
			xb_s2_q <= xb_s1_q;
			wa_s1_q <= wide_address_strap_in;
			wa_s2_q <= wa_s1_q;
		end
	end

	// capture sequence and mode bits, next values
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sec_d  = sec_q;
		map_d  = map_q;
		wide_d = wide_q;
		ign_d  = 1'b0;
		unique case (st_q)
			// wait until synchronisers hold real strap levels
			ST_SYNC: begin
				cnt_d = cnt_q + 2'h1;
				if (cnt_q == SYNC_WAIT) begin
					st_d = ST_LOAD;
				end
			end
			// straps are caught once, after reset release
			ST_LOAD: begin
				sec_d  = ~flash_secured_in;
				// secured part cannot boot externally
				map_d  = xb_s2_q & ~flash_secured_in;
				// width strap matters only for external boot
				wide_d = xb_s2_q & ~flash_secured_in & wa_s2_q;
				st_d   = ST_RUN;
			end
			// normal operation
			ST_RUN: begin
				// secure bit left alone: only reset reloads it
				sec_d = sec_q;
				if (map_select_wr_in && sec_q) begin
					map_d = map_select_wdata_in;
				end
				// write is acknowledged but discarded
				ign_d = secure_boot_wr_in;
			end
		endcase
	end

	// capture sequence and mode bits, registers
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q   <= ST_SYNC;
			cnt_q  <= 2'h0;
			sec_q  <= RST_BIT;
			map_q  <= RST_BIT;
			wide_q <= RST_BIT;
			ign_q  <= RST_BIT;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sec_q  <= sec_d;
			map_q  <= map_d;
			wide_q <= wide_d;
			ign_q  <= ign_d;
		end
	end

	// fetch decode and flash control, next values
	always_comb begin
		logic       ext_map;
		logic       reach;
		logic       blk;
		ext_map = map_q & sec_q;
		reach   = 1'b0;
		blk     = fetch_addr_in[FLASH_BLK_BIT];
		rg_d    = RG_NONE;
		blk_d   = 1'b0;
		stall_d = 1'b0;
		ers_d   = 2'h0;
		// vectors follow the current map
		if (ext_map && !wide_q) begin
			bv_d = VEC_EXT_BOOT;
			wv_d = VEC_EXT_WDOG;
		end else begin
			// internal boot, or wide external shadow
			bv_d = VEC_INT_BOOT;
			wv_d = VEC_INT_WDOG;
		end
		if (st_q == ST_RUN) begin
			reach = ext_reach(fetch_addr_in, sec_q, wide_q,
				mid_addr_pins_in, top_addr_pins_in);
			if (fetch_valid_in) begin
				rg_d = map_region(fetch_addr_in, ext_map,
					wide_q, reach);
				if (rg_d == RG_FLASH) begin
					// only the busy block holds execution
					blk_d   = blk;
					stall_d = flash_busy_in[blk];
				end
			end
			// each block erases on its own request
			for (int b = 0; b < NBLK; b++) begin
				ers_d[b] = erase_req_in[b] &
					~flash_busy_in[b];
			end
		end
	end

	// fetch decode and flash control, registers
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rg_q    <= RG_NONE;
			blk_q   <= RST_BIT;
			stall_q <= RST_BIT;
			ers_q   <= 2'h0;
			bv_q    <= VEC_INT_BOOT;
			wv_q    <= VEC_INT_WDOG;
		end else begin
			rg_q    <= rg_d;
			blk_q   <= blk_d;
			stall_q <= stall_d;
			ers_q   <= ers_d;
			bv_q    <= bv_d;
			wv_q    <= wv_d;
		end
	end

	// pin roles, registered from mode state
	logic        rdy_q;     // straps captured
	logic        rdy_d;
	logic        dbg_q;     // debug unit enable
	logic        dbg_d;
	logic        extp_q;    // external p-space allowed
	logic        extp_d;
	logic [3:0]  hi_q;      // gpio as address 19:16
	logic [3:0]  hi_d;
	logic        psel_q;    // chip select zero is program strobe
	logic        psel_d;
	logic        dsel_q;    // chip select one is data strobe
	logic        dsel_d;

	// role next values; taken from next mode bits so both land together
	always_comb begin
		rdy_d  = (st_q == ST_RUN);
		// secured part keeps debug and external p-space shut
		dbg_d  = sec_d;
		extp_d = sec_d;
		// a20-23 are never touched here
		hi_d   = {4{wide_d}};
		// older bus family roles, held constant: no input moves them
		psel_d = RST_ROLE;
		dsel_d = RST_ROLE;
	end

	// role flops; chip select roles fixed out of reset
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdy_q  <= RST_BIT;
			dbg_q  <= RST_BIT;
			extp_q <= RST_BIT;
			hi_q   <= 4'h0;
			psel_q <= RST_ROLE;
			dsel_q <= RST_ROLE;
		end else begin
			rdy_q  <= rdy_d;
			dbg_q  <= dbg_d;
			extp_q <= extp_d;
			hi_q   <= hi_d;
			psel_q <= psel_d;
			dsel_q <= dsel_d;
		end
	end

	// outputs straight from flops
	assign mode_ready_out         = rdy_q;
	assign map_select_bit_out     = map_q;
	assign secure_boot_bit_out    = sec_q;
	assign wide_bus_out           = wide_q;
	assign debug_enable_out       = dbg_q;
	assign ext_pspace_allow_out   = extp_q;
	assign addr_hi_pins_out       = hi_q;
	assign chip_select_zero_out   = psel_q;
	assign chip_select_one_out    = dsel_q;
	assign sb_write_ignored_out   = ign_q;
	assign boot_vector_out        = bv_q;
	assign wdog_vector_out        = wv_q;
	assign region_out             = rg_q;
	assign flash_block_out        = blk_q;
	assign fetch_stall_out        = stall_q;
	assign mass_erase_out         = ers_q;
endmodule : bmap_top

// ### bmap_strap_model.sv
// board side model: strap pins set by the fitted ties
`timescale 1ns/100ps
module bmap_strap_model (
	// board build choices
	input  wire logic	ext_tie_in,
	input  wire logic	wide_tie_in,
	// strap pin levels seen by the block
	output logic	external_boot_strap_out,
	output logic	wide_address_strap_out
);
	// ties are static, so straps never move while the block samples them
	assign external_boot_strap_out = ext_tie_in;
	assign wide_address_strap_out = wide_tie_in;
endmodule : bmap_strap_model

// ### bmap_checker.sv
// concurrent checks on the boot map block ports
`timescale 1ns/100ps
module bmap_checker
	import bmap_pkg::*;
(
	// clock and reset
	input  wire logic                   ref_clk_in,
	input  wire logic                   resetn_in,
	// software and fetch inputs
	input  wire logic                   map_select_wr_in,
	input  wire logic                   map_select_wdata_in,
	input  wire logic                   secure_boot_wr_in,
	input  wire logic                   mid_addr_pins_in,
	input  wire logic                   fetch_valid_in,
	input  wire logic [1:0]             flash_busy_in,
	input  wire logic [1:0]             erase_req_in,
	// mode outputs
	input  wire logic                   mode_ready_out,
	input  wire logic                   map_select_bit_out,
	input  wire logic                   secure_boot_bit_out,
	input  wire logic                   wide_bus_out,
	input  wire logic                   debug_enable_out,
	input  wire logic                   ext_pspace_allow_out,
	input  wire logic                   sb_write_ignored_out,
	input  wire logic                   chip_select_zero_out,
	input  wire logic                   chip_select_one_out,
	input  wire logic [3:0]             addr_hi_pins_out,
	// vectors, fetch answer and erase launch
	input  wire bmap_pkg::bmap_addr_t   boot_vector_out,
	input  wire bmap_pkg::bmap_addr_t   wdog_vector_out,
	input  wire bmap_pkg::bmap_region_t region_out,
	input  wire logic [1:0]             mass_erase_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// running flag and narrow external map, used a cycle late for vectors
	wire rdy = mode_ready_out;
	wire xn = map_select_bit_out & secure_boot_bit_out & ~wide_bus_out;
	sec_hold_a: assert property (rdy |=> $stable(secure_boot_bit_out))
		else $error("secure bit changed while running");
	secured_lock_a: assert property (rdy && !secure_boot_bit_out |->
		!debug_enable_out && !ext_pspace_allow_out && !wide_bus_out
		&& !map_select_bit_out) else $error("secured mode not locked");
	map_write_a: assert property (rdy && map_select_wr_in |=>
		map_select_bit_out == ($past(secure_boot_bit_out)
		&& $past(map_select_wdata_in))) else $error("map bit write wrong");
	vec_track_a: assert property (rdy && $past(rdy) |->
		boot_vector_out == ($past(xn) ? VEC_EXT_BOOT : VEC_INT_BOOT)
		&& wdog_vector_out == ($past(xn) ? VEC_EXT_WDOG : VEC_INT_WDOG))
		else $error("vectors do not follow map");
	one_region_a: assert property (rdy && fetch_valid_in |=>
		$onehot(region_out)) else $error("fetch region not one-hot");
	no_fetch_a: assert property (!fetch_valid_in |=>
		region_out == RG_NONE) else $error("region without fetch");
	erase_gate_a: assert property (rdy |=>
		mass_erase_out == $past(erase_req_in & ~flash_busy_in))
		else $error("erase launch wrong");
	sb_ignore_a: assert property (rdy |=>
		sb_write_ignored_out == $past(secure_boot_wr_in))
		else $error("secure write pulse wrong");
	cs_roles_a: assert property ($rose(rdy) |->
		chip_select_zero_out && chip_select_one_out)
		else $error("chip select roles wrong");
	addr_hi_a: assert property (rdy && !mid_addr_pins_in |->
		addr_hi_pins_out == {4{wide_bus_out}})
		else $error("upper address pins wrong");
endmodule : bmap_checker
bind bmap_top bmap_checker chk_u (.*);

// ### tb_bmap_top.sv
// self-checking bench for boot mode capture and program map decode
`timescale 1ns/100ps
module tb_bmap_top;
	import bmap_pkg::*;
	// stimulus, all given at time zero
	logic	ref_clk_in = 1'b0, resetn_in = 1'b0, flash_secured_in = 1'b0;
	logic	map_select_wr_in = 1'b0, map_select_wdata_in = 1'b0;
	logic	secure_boot_wr_in = 1'b0, mid_addr_pins_in = 1'b0;
	logic	top_addr_pins_in = 1'b0, fetch_valid_in = 1'b0;
	logic	ext_tie = 1'b0, wide_tie = 1'b0;
	bmap_addr_t	fetch_addr_in = 21'h000000;
	logic [1:0]	flash_busy_in = 2'h0, erase_req_in = 2'h0;
	// observed outputs and strap pins
	logic	external_boot_strap_in, wide_address_strap_in, mode_ready_out;
	logic	map_select_bit_out, secure_boot_bit_out, wide_bus_out;
	logic	debug_enable_out, ext_pspace_allow_out, chip_select_zero_out;
	logic	chip_select_one_out, sb_write_ignored_out, flash_block_out;
	logic	fetch_stall_out;
	logic [3:0]	addr_hi_pins_out;
	logic [1:0]	mass_erase_out;
	bmap_addr_t	boot_vector_out, wdog_vector_out;
	bmap_region_t	region_out;
	int	n_mismatch = 0, check_count = 0, cyc = 0;
	bmap_top dut_u (.*);
	bmap_strap_model strap_u (.ext_tie_in(ext_tie), .wide_tie_in(wide_tie),
		.external_boot_strap_out(external_boot_strap_in),
		.wide_address_strap_out(wide_address_strap_in));
	// 125 MHz clock
	always #4 ref_clk_in = ~ref_clk_in;
	// hang guard, the run needs about a hundred cycles
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [20:0] seen,
		input logic [20:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// reset with given flash state and straps, then judge the capture
	task automatic boot(input logic s, input logic e, input logic w);
		int i;
		logic x;
		logic ns;
		resetn_in = 1'b0;
		flash_secured_in = s;
		ext_tie = e;
		wide_tie = w;
		x = e & ~s & ~w;
		// one-bit inverse, so the check argument is not widened first
		ns = ~s;
		repeat (3) @(negedge ref_clk_in);
		resetn_in = 1'b1;
		for (i = 0; i < 20 && mode_ready_out !== 1'b1; i++)
			@(negedge ref_clk_in);
		chk("ready", mode_ready_out, 1'b1);
		chk("secure_bit", secure_boot_bit_out, ns);
		chk("map_bit", map_select_bit_out, e & ns);
		chk("wide", wide_bus_out, e & ns & w);
		chk("debug", debug_enable_out, ns);
		chk("ext_allow", ext_pspace_allow_out, ns);
		chk("cs_zero", chip_select_zero_out, 1'b1);
		chk("cs_one", chip_select_one_out, 1'b1);
		chk("addr_hi", addr_hi_pins_out, {4{e & ~s & w}});
		chk("boot_vec", boot_vector_out,
			x ? VEC_EXT_BOOT : VEC_INT_BOOT);
		chk("wdog_vec", wdog_vector_out,
			x ? VEC_EXT_WDOG : VEC_INT_WDOG);
	endtask : boot
	// one fetch, answer stands in the next cycle; valid stays up
	task automatic fetch(input bmap_addr_t a, input bmap_region_t r);
		fetch_valid_in = 1'b1;
		fetch_addr_in = a;
		@(negedge ref_clk_in);
		chk("region", region_out, r);
	endtask : fetch
	// map bit write; m expected bit, x expected external vectors
	task automatic wr_ma(input logic v, input logic m, input logic x);
		map_select_wr_in = 1'b1;
		map_select_wdata_in = v;
		@(negedge ref_clk_in);
		map_select_wr_in = 1'b0;
		chk("map_bit", map_select_bit_out, m);
		@(negedge ref_clk_in);
		chk("boot_vec", boot_vector_out,
			x ? VEC_EXT_BOOT : VEC_INT_BOOT);
	endtask : wr_ma
	task automatic t_modes();
		boot(1'b0, 1'b0, 1'b1);
		boot(1'b0, 1'b1, 1'b0);
		boot(1'b1, 1'b0, 1'b0);
		boot(1'b1, 1'b1, 1'b1);
	endtask : t_modes
	// narrow external boot, reach grows with software pins
	task automatic t_narrow();
		boot(1'b0, 1'b1, 1'b0);
		fetch(21'h000000, RG_EXT);
		fetch(21'h010000, RG_FLASH);
		fetch(21'h040002, RG_BOOT);
		fetch(21'h050000, RG_RSVD);
		mid_addr_pins_in = 1'b1;
		fetch(21'h050000, RG_EXT);
		fetch(21'h100000, RG_RSVD);
		top_addr_pins_in = 1'b1;
		fetch(21'h100000, RG_EXT);
		fetch_valid_in = 1'b0;
		mid_addr_pins_in = 1'b0;
		top_addr_pins_in = 1'b0;
	endtask : t_narrow
	task automatic t_wide();
		boot(1'b0, 1'b1, 1'b1);
		fetch(21'h040000, RG_EXT);
		fetch(21'h020000, RG_FLASH);
		chk("block", flash_block_out, 1'b1);
		fetch(21'h0fffff, RG_EXT);
		fetch(21'h100000, RG_RSVD);
		fetch_valid_in = 1'b0;
	endtask : t_wide
	// internal boot: regions, busy block, erase, software writes
	task automatic t_int();
		boot(1'b0, 1'b0, 1'b0);
		flash_busy_in = 2'h2;
		erase_req_in = 2'h3;
		fetch(21'h01ffff, RG_FLASH);
		chk("block", flash_block_out, 1'b0);
		chk("erase", mass_erase_out, 2'h1);
		erase_req_in = 2'h0;
		fetch(21'h020000, RG_FLASH);
		chk("stall", fetch_stall_out, 1'b1);
		fetch(21'h04f800, RG_PRAM);
		fetch(21'h04f7ff, RG_RSVD);
		fetch(21'h050000, RG_RSVD);
		fetch_valid_in = 1'b0;
		flash_busy_in = 2'h0;
		wr_ma(1'b1, 1'b1, 1'b1);
		fetch(21'h000000, RG_EXT);
		wr_ma(1'b0, 1'b0, 1'b0);
		fetch(21'h000000, RG_FLASH);
		fetch_valid_in = 1'b0;
		secure_boot_wr_in = 1'b1;
		@(negedge ref_clk_in);
		secure_boot_wr_in = 1'b0;
		chk("sb_ignored", sb_write_ignored_out, 1'b1);
		chk("secure_bit", secure_boot_bit_out, 1'b1);
	endtask : t_int
	// secured part: map write refused, unlock not seen until reset
	task automatic t_sec();
		boot(1'b1, 1'b0, 1'b0);
		wr_ma(1'b1, 1'b0, 1'b0);
		top_addr_pins_in = 1'b1;
		fetch(21'h100000, RG_RSVD);
		fetch_valid_in = 1'b0;
		top_addr_pins_in = 1'b0;
		flash_secured_in = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		chk("secure_bit", secure_boot_bit_out, 1'b0);
	endtask : t_sec
	initial begin
		t_modes();
		t_narrow();
		t_wide();
		t_int();
		t_sec();
		end_sim();
	end
endmodule : tb_bmap_top
